// file: src/irq_ctrl.sv
// Two-level priority interrupt controller with AHB-Lite register port
//
// Summary of operation
// (RL1) Five sources: two external pins, two timer overflows, serial unit.
// (RL2) Each external input picks falling edge or low level by its type bit.
// (RL3) Event sets pending flag; interrupt only when its enable bit is set.
// (RL4) Edge-mode external flag clears when its vector is taken.
// (RL5) Level-mode external flag follows the pin, vectoring does not clear.
// (RL6) Timer requests come from overflow flags set on rollover.
// (RL7) Timer flag clears when its vector is fetched, only if enabled.
// (RL8) Serial unit requests on frame done; errored received frames ignored.
// (RL9) Two levels; each source chooses its level by a priority bit.
// (RL10) High preempts low service; high service is never preempted.
// (RL11) Same level order: ext0, timer0, ext1, timer1, serial.
// (RL12) Flags sampled each machine cycle, polled in the next.
// (RL13) Unblocked captured request makes the core run a long call.
// (RL14) Machine cycle is twelve oscillator periods.
// (RL15) Call blocked by equal/higher service, mid-instruction, return or reg write; only enable and priority register writes block here.
// (RL16) Blocked requests are not remembered; each poll is fresh.
// (RL17) Global enable gates all five sources.
// (RL18) Priority bit set means high level, clear means low.
// (RL19) Level in service is recorded and released on return from interrupt.
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module irq_ctrl
	import irq_ctrl_pkg::*;
(
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_I,
	// AHB-Lite slave
	input  wire logic        HSEL_I,
	input  wire logic [7:0]  HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	output logic [31:0]      HRDATA_O,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	// Request sources
	input  wire logic        EXT_REQUEST_PIN_0_N_I,
	input  wire logic        EXT_REQUEST_PIN_1_N_I,
	input  wire logic        TIMER0_ROLLOVER_I,
	input  wire logic        TIMER1_ROLLOVER_I,
	input  wire logic        SER_FRAME_DONE_I,
	input  wire logic        SER_FRAME_ERROR_I,
	// Core handshake
	input  wire logic        LAST_INSN_CYCLE_I,
	input  wire logic        RETURN_FROM_IRQ_I,
	input  wire logic        VECTOR_TAKEN_I,
	output logic             LONG_CALL_REQ_O,
	output logic [15:0]      LONG_CALL_ADDR_O,
	output logic             MCYCLE_TICK_O,
	output logic             IRQ_O
);
	////////////////////////////////////////////////////////////////////////////
	// Machine cycle divider
	logic [DIV_W-1:0] div_q;
	logic             tick;
	assign tick = (div_q == DIV_W'(MCYCLE_CLKS - 1));
	// (RL14) Twelve clock machine cycle
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) div_q <= '0;
		else if (tick) div_q <= '0;
		else div_q <= div_q + 1'b1;
	end
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) MCYCLE_TICK_O <= 1'b0;
		else MCYCLE_TICK_O <= tick;
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus slave
	logic       wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [7:0] timer_control_register_q;     // Bit 0 type of ext0, bit 2 type of ext1
	logic [7:0] enable_q;
	logic [7:0] prio_q;
	logic [1:0] evt_mask_q;
	logic       wr_ctrl, wr_en, wr_prio, wr_istat, wr_imask;
	logic       addr_ok;
	assign addr_ok  = HSEL_I && HREADY_I && HTRANS_I[1];
	assign wr_ctrl  = wr_pend_q && (wr_addr_q == OFS_CTRL);
	assign wr_en    = wr_pend_q && (wr_addr_q == OFS_ENABLE);
	assign wr_prio  = wr_pend_q && (wr_addr_q == OFS_PRIO);
	assign wr_istat = wr_pend_q && (wr_addr_q == OFS_IRQ_STAT);
	assign wr_imask = wr_pend_q && (wr_addr_q == OFS_IRQ_MASK);

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end else begin
			wr_pend_q <= addr_ok && HWRITE_I;
			wr_addr_q <= HADDR_I;
		end
	end
	// Slave answers with zero wait states
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end else begin
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			timer_control_register_q   <= RST_BYTE;
			enable_q <= RST_BYTE;
			prio_q   <= RST_BYTE;
		end else begin
			// (RL2) Type select bits 0 and 2
			if (wr_ctrl) timer_control_register_q <= {5'h00, HWDATA_I[2], 1'b0, HWDATA_I[0]};
			// (RL17) Global enable at bit 7
			if (wr_en) enable_q <= {HWDATA_I[7], 2'h0, HWDATA_I[4:0]};
			if (wr_prio) prio_q <= {3'h0, HWDATA_I[4:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Request flags
	logic       pin0_q, pin1_q;
	logic [4:0] flag;
	logic       ext_edge0_q, ext_edge1_q, tmr0_q, tmr1_q, ser_q;
	logic       type0, type1;
	logic [4:0] clr_vec;    // Vector taken for source
	logic [2:0] sel_q;
	logic       call_pend_q;
	assign type0 = timer_control_register_q[0];
	assign type1 = timer_control_register_q[2];
	assign clr_vec = (call_pend_q && VECTOR_TAKEN_I) ? (5'h01 << sel_q) : 5'h00;

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			pin0_q <= 1'b1;
			pin1_q <= 1'b1;
		end else begin
			pin0_q <= EXT_REQUEST_PIN_0_N_I;
			pin1_q <= EXT_REQUEST_PIN_1_N_I;
		end
	end

	// (RL4) Edge flags set on fall, cleared on vector; set wins
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			ext_edge0_q <= 1'b0;
			ext_edge1_q <= 1'b0;
		end else begin
			if (pin0_q && !EXT_REQUEST_PIN_0_N_I) ext_edge0_q <= 1'b1;
			else if (clr_vec[SRC_EXT0] || !type0) ext_edge0_q <= 1'b0;
			if (pin1_q && !EXT_REQUEST_PIN_1_N_I) ext_edge1_q <= 1'b1;
			else if (clr_vec[SRC_EXT1] || !type1) ext_edge1_q <= 1'b0;
		end
	end
	// (RL6) Overflow flags; (RL7) cleared on vector fetch
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			tmr0_q <= 1'b0;
			tmr1_q <= 1'b0;
		end else begin
			if (TIMER0_ROLLOVER_I) tmr0_q <= 1'b1;
			else if (clr_vec[SRC_TMR0]) tmr0_q <= 1'b0;
			if (TIMER1_ROLLOVER_I) tmr1_q <= 1'b1;
			else if (clr_vec[SRC_TMR1]) tmr1_q <= 1'b0;
		end
	end
	// (RL8) Serial request, errored frames ignored; cleared on vector
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) ser_q <= 1'b0;
		else if (SER_FRAME_DONE_I && !SER_FRAME_ERROR_I) ser_q <= 1'b1;
		else if (clr_vec[SRC_SER]) ser_q <= 1'b0;
	end

	// (RL5) Level mode follows the pin directly
	// (RL1) Five sources in polling order
	assign flag = {ser_q, tmr1_q, type1 ? ext_edge1_q : !pin1_q,
		tmr0_q, type0 ? ext_edge0_q : !pin0_q};

	////////////////////////////////////////////////////////////////////////////
	// Sampling and polling
	logic [4:0] sample_q;
	logic [4:0] req_hi, req_lo;
	logic       any_hi, any_lo;
	logic [2:0] idx_hi, idx_lo;
	logic [1:0] insvc_q;    // [1] high level in service, [0] low level
	logic       blocked_q;  // Enable or priority write, or return, seen this machine cycle
	logic       grant_hi, grant_lo;

	// (RL12) Capture flags once per machine cycle
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) sample_q <= '0;
		else if (tick) sample_q <= flag;
	end

	// (RL3) Enable gating; (RL17) global enable; (RL9) (RL18) level split
	assign req_hi = sample_q & enable_q[4:0] & {5{enable_q[EN_GLOBAL_BIT]}} & prio_q[4:0];
	assign req_lo = sample_q & enable_q[4:0] & {5{enable_q[EN_GLOBAL_BIT]}} & ~prio_q[4:0];

	// (RL11) Fixed order within each level
	irq_prio_pick #(.N(NUM_SRC)) u_pick_hi (
		.req_i (req_hi),
		.any_o (any_hi),
		.idx_o (idx_hi)
	);
	irq_prio_pick #(.N(NUM_SRC)) u_pick_lo (
		.req_i (req_lo),
		.any_o (any_lo),
		.idx_o (idx_lo)
	);

	// Clears on the polling edge, so a write landing on that edge is blocked separately
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) blocked_q <= 1'b0;
		else if (tick) blocked_q <= 1'b0;
		else if (wr_en || wr_prio || RETURN_FROM_IRQ_I) blocked_q <= 1'b1;
	end

	// (RL10) (RL15) Equal or higher level in service blocks
	assign grant_hi = any_hi && !insvc_q[1];
	assign grant_lo = any_lo && !insvc_q[1] && !insvc_q[0];

	// (RL13) Issue long call at polling edge; (RL16) no memory of blocked polls
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			call_pend_q      <= 1'b0;
			sel_q            <= '0;
			LONG_CALL_REQ_O  <= 1'b0;
			LONG_CALL_ADDR_O <= '0;
		end else if (call_pend_q) begin
			if (VECTOR_TAKEN_I) begin
				call_pend_q     <= 1'b0;
				LONG_CALL_REQ_O <= 1'b0;
			end
		end else if (tick && LAST_INSN_CYCLE_I && !blocked_q && !RETURN_FROM_IRQ_I
				&& !wr_en && !wr_prio && (grant_hi || grant_lo)) begin
			call_pend_q      <= 1'b1;
			LONG_CALL_REQ_O  <= 1'b1;
			sel_q            <= grant_hi ? idx_hi : idx_lo;
			LONG_CALL_ADDR_O <= VEC_ADDR[grant_hi ? idx_hi : idx_lo];
		end
	end

	logic sel_hi_q;
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) sel_hi_q <= 1'b0;
		else if (!call_pend_q) sel_hi_q <= grant_hi;
	end

	// (RL19) Record level in service, release on return
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) insvc_q <= 2'h0;
		else if (call_pend_q && VECTOR_TAKEN_I) begin
			if (sel_hi_q) insvc_q[1] <= 1'b1;
			else insvc_q[0] <= 1'b1;
		end else if (RETURN_FROM_IRQ_I) begin
			if (insvc_q[1]) insvc_q[1] <= 1'b0;
			else insvc_q[0] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Event status with mask, write one to clear
	logic [1:0] evt_stat_q;
	logic [1:0] evt_set;
	assign evt_set = {RETURN_FROM_IRQ_I, call_pend_q && VECTOR_TAKEN_I};
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) evt_stat_q <= '0;
		else evt_stat_q <= evt_set | (evt_stat_q & ~(wr_istat ? HWDATA_I[1:0] : 2'h0));
	end
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) evt_mask_q <= '0;
		else if (wr_imask) evt_mask_q <= HWDATA_I[1:0];
	end
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) IRQ_O <= 1'b0;
		else IRQ_O <= |(evt_stat_q & evt_mask_q);
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) HRDATA_O <= '0;
		else if (addr_ok && !HWRITE_I) begin
			unique case (HADDR_I)
				OFS_CTRL:     HRDATA_O <= {24'h0, 4'h0, ext_edge1_q, timer_control_register_q[2],
					ext_edge0_q, timer_control_register_q[0]};
				OFS_ENABLE:   HRDATA_O <= {24'h0, enable_q};
				OFS_PRIO:     HRDATA_O <= {24'h0, prio_q};
				OFS_STATUS:   HRDATA_O <= {21'h0, sel_q, insvc_q, call_pend_q, flag};
				OFS_IRQ_STAT: HRDATA_O <= {30'h0, evt_stat_q};
				OFS_IRQ_MASK: HRDATA_O <= {30'h0, evt_mask_q};
				default:      HRDATA_O <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	a_tick_period: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL14)
		tick |=> !tick [*8] ##1 !tick [*3] ##1 tick)
		else $error("machine cycle not twelve clocks");
	a_call_needs_en: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL17)
		$rose(LONG_CALL_REQ_O) |-> enable_q[EN_GLOBAL_BIT]) else $error("call with global off");
	a_call_on_tick: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL12)
		$rose(LONG_CALL_REQ_O) |-> $past(tick)) else $error("call off machine cycle edge");
	a_call_last_cyc: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL15)
		$rose(LONG_CALL_REQ_O) |-> $past(LAST_INSN_CYCLE_I)) else $error("call mid instruction");
	a_hi_not_preempt: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL10)
		$rose(LONG_CALL_REQ_O) |-> !insvc_q[1]) else $error("high service preempted");
	a_tmr_clear: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL7)
		call_pend_q && VECTOR_TAKEN_I && sel_q == 3'(SRC_TMR0) && !TIMER0_ROLLOVER_I
		|=> !tmr0_q) else $error("timer flag not cleared");
	a_edge_set: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL4)
		pin0_q && !EXT_REQUEST_PIN_0_N_I |=> ext_edge0_q) else $error("edge not caught");
	a_ser_err: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL8)
		!ser_q && SER_FRAME_ERROR_I && !clr_vec[SRC_SER] |=> !ser_q) else $error("errored frame");
	a_order_ext0: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL11)
		req_hi[0] |-> idx_hi == 3'h0) else $error("polling order wrong");
	a_tmr1_clear: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL7)
		call_pend_q && VECTOR_TAKEN_I && sel_q == 3'(SRC_TMR1) && !TIMER1_ROLLOVER_I
		|=> !tmr1_q) else $error("timer 1 flag not cleared");
	a_ext_clear: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL4)
		call_pend_q && VECTOR_TAKEN_I && sel_q == 3'(SRC_EXT0)
		&& !(pin0_q && !EXT_REQUEST_PIN_0_N_I) |=> !ext_edge0_q) else $error("edge flag kept");
	a_call_blk_wr: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL15)
		$rose(LONG_CALL_REQ_O) |-> !$past(wr_en || wr_prio || RETURN_FROM_IRQ_I))
		else $error("call in blocked cycle");
	a_lo_no_nest: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL10)
		$rose(LONG_CALL_REQ_O) && !sel_hi_q |-> insvc_q == 2'h0) else $error("low call nested");
	a_svc_record: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL19)
		call_pend_q && VECTOR_TAKEN_I |=> insvc_q != 2'h0) else $error("service level lost");
	a_call_stands: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // (RL13)
		LONG_CALL_REQ_O && !VECTOR_TAKEN_I |=> LONG_CALL_REQ_O && $stable(LONG_CALL_ADDR_O))
		else $error("call dropped early");
	c_hi_call: cover property (@(posedge CLK_SYS_I) $rose(LONG_CALL_REQ_O) && sel_hi_q);
	c_call: cover property (@(posedge CLK_SYS_I) $rose(LONG_CALL_REQ_O));
	c_preempt: cover property (@(posedge CLK_SYS_I) insvc_q == 2'h3);
	c_irq: cover property (@(posedge CLK_SYS_I) IRQ_O);
endmodule // irq_ctrl

// file: src/irq_ctrl_pkg.sv
// Package: constants for the two-level interrupt controller
package irq_ctrl_pkg;
	localparam int unsigned NUM_SRC          = 5;
	localparam int unsigned OSC_PER_MCYCLE   = 12;
	localparam int unsigned CLK_PERIOD_NS    = 50;
	localparam int unsigned MCYCLE_CLKS      = OSC_PER_MCYCLE;
	localparam int unsigned DIV_W            = 4;
	// Source indexes in fixed polling order
	localparam int unsigned SRC_EXT0         = 0;
	localparam int unsigned SRC_TMR0         = 1;
	localparam int unsigned SRC_EXT1         = 2;
	localparam int unsigned SRC_TMR1         = 3;
	localparam int unsigned SRC_SER          = 4;
	// Bit positions inside the enable register
	localparam int unsigned EN_GLOBAL_BIT    = 7;
	// Vector addresses, one per source
	localparam logic [15:0] VEC_ADDR [NUM_SRC] = '{16'h0003, 16'h000B, 16'h0013,
		16'h001B, 16'h0023};
	// AHB-Lite register byte offsets
	localparam logic [7:0]  OFS_CTRL         = 8'h00;
	localparam logic [7:0]  OFS_ENABLE       = 8'h04;
	localparam logic [7:0]  OFS_PRIO         = 8'h08;
	localparam logic [7:0]  OFS_STATUS       = 8'h0C;
	localparam logic [7:0]  OFS_IRQ_STAT     = 8'h10;
	localparam logic [7:0]  OFS_IRQ_MASK     = 8'h14;
	localparam logic [7:0]  RST_BYTE         = 8'h00;
	localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ       = 2'h3;
endpackage : irq_ctrl_pkg

// file: src/irq_prio_pick.sv
// Fixed-order request picker for one priority level
`timescale 1ns/1ps
module irq_prio_pick
	import irq_ctrl_pkg::*;
#(
	parameter int unsigned N = NUM_SRC
) (
	input  wire logic [N-1:0] req_i,
	output logic              any_o,
	output logic [2:0]        idx_o
);
	// Lowest index wins: external 0 first, serial unit last
	always_comb begin
		any_o = 1'b0;
		idx_o = 3'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req_i[i]) begin
				any_o = 1'b1;
				idx_o = 3'(i);
			end
		end
	end
endmodule // irq_prio_pick

// file: sim/core_model.sv
// Behavioural core sequencer that answers long calls and returns
`timescale 1ns/1ps
module core_model (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic call_req_i,
	input  wire logic hold_i,
	input  wire logic slow_i,
	input  wire logic ret_go_i,
	output logic      last_insn_o,
	output logic      vector_taken_o,
	output logic      return_o
);
	logic [2:0] wait_q;
	////////////////////////////////////////////////////////////////
	// mid-instruction hold
	assign last_insn_o = !hold_i;
	// acknowledge long call; slow mode lets the request stand longer
	always_ff @(posedge clk_i) begin
		if (rst_i || !call_req_i || vector_taken_o) begin
			wait_q         <= 3'h0;
			vector_taken_o <= 1'b0;
		end else if (wait_q == (slow_i ? 3'h6 : 3'h0)) begin
			vector_taken_o <= 1'b1;
		end else begin
			wait_q <= wait_q + 3'h1;
		end
	end
	always_ff @(posedge clk_i) begin
		return_o <= ret_go_i && !rst_i;
	end
endmodule // core_model

// file: sim/irq_ctrl_tb.sv
// Self-checking testbench for the two-level interrupt controller
`timescale 1ns/1ps
module irq_ctrl_tb;
	import irq_ctrl_pkg::*;
	logic        clk, rst, hsel, hwrite, hready, hresp, pin0_n, pin1_n, tmr0, tmr1;
	logic        ser_done, ser_err, last_insn, ret_irq, vec_taken, call_req, irq;
	logic        hold, slow, ret_go, mtick;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, st;
	logic [15:0] call_addr;
	int          bad_count, n_compared;

	irq_ctrl irq_ctrl_i (.CLK_SYS_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
		.HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.EXT_REQUEST_PIN_0_N_I(pin0_n), .EXT_REQUEST_PIN_1_N_I(pin1_n),
		.TIMER0_ROLLOVER_I(tmr0), .TIMER1_ROLLOVER_I(tmr1), .SER_FRAME_DONE_I(ser_done),
		.SER_FRAME_ERROR_I(ser_err), .LAST_INSN_CYCLE_I(last_insn),
		.RETURN_FROM_IRQ_I(ret_irq), .VECTOR_TAKEN_I(vec_taken),
		.LONG_CALL_REQ_O(call_req), .LONG_CALL_ADDR_O(call_addr), .MCYCLE_TICK_O(mtick),
		.IRQ_O(irq));
	core_model core_model_i (.clk_i(clk), .rst_i(rst), .call_req_i(call_req),
		.hold_i(hold), .slow_i(slow), .ret_go_i(ret_go), .last_insn_o(last_insn),
		.vector_taken_o(vec_taken), .return_o(ret_irq));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Single AHB-Lite transfer; called just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rdata);
		int n;
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		n = 0;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 20);
		chk("hready_addr", 32'(hready), 32'h1);
		htrans <= 2'h0;
		hwdata <= wd;
		n = 0;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 20);
		chk("hready_data", 32'(hready), 32'h1);
		rdata = hrdata;
		chk("hresp", 32'(hresp), 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0, st);
	endtask
	task automatic pulse(input logic [2:0] m);
		{ser_done, tmr1, tmr0} <= m;
		@(posedge clk);
		{ser_done, tmr1, tmr0} <= 3'h0;
	endtask
	task automatic ret();
		ret_go <= 1'b1;
		@(posedge clk);
		ret_go <= 1'b0;
	endtask
	// Waits for a call, checks its vector, then waits for the core to take it
	task automatic wait_call(input logic [15:0] exp);
		int n;
		n = 0;
		while (call_req !== 1'b1 && n < 80) begin @(negedge clk); n++; end
		chk("call_req", 32'(call_req), 32'h1);
		chk("call_addr", 32'(call_addr), 32'(exp));
		n = 0;
		while (call_req !== 1'b0 && n < 20) begin @(negedge clk); n++; end
		chk("call_done", 32'(call_req), 32'h0);
		@(posedge clk);
	endtask
	// Counts clocks between two machine cycle ticks
	task automatic t_tick();
		int n;
		n = 0;
		do begin @(negedge clk); n++; end while (mtick !== 1'b1 && n < 40);
		n = 0;
		do begin @(negedge clk); n++; end while (mtick !== 1'b1 && n < 40);
		chk("tick_period", 32'(n), 32'(MCYCLE_CLKS));
		@(posedge clk);
	endtask
	task automatic no_call(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin @(negedge clk); seen = seen | (call_req !== 1'b0); end
		@(posedge clk);
		chk("no_call", 32'(seen), 32'h0);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd(OFS_ENABLE);
		chk("enable_rst", st, 32'h0);
		wr(OFS_PRIO, 32'h1F);
		rd(OFS_PRIO);
		chk("prio_rw", st & 32'h1F, 32'h1F);
		wr(OFS_PRIO, 32'h0);
		rd(8'h3C);
		chk("unmapped", st, 32'h0);
	endtask
	task automatic t_order();
		wr(OFS_ENABLE, 32'h9F);
		pulse(3'h7);
		wait_call(VEC_ADDR[SRC_TMR0]);
		rd(OFS_STATUS);
		chk("tmr_flags", st & 32'h0A, 32'h08);
		no_call(40);
		ret();
		wait_call(VEC_ADDR[SRC_TMR1]);
		ret();
		wait_call(VEC_ADDR[SRC_SER]);
		ret();
	endtask
	task automatic t_gate();
		wr(OFS_ENABLE, 32'h02);
		pulse(3'h1);
		no_call(40);
		rd(OFS_STATUS);
		chk("pend_flag", st & 32'h1F, 32'h02);
		wr(OFS_ENABLE, 32'h82);
		wait_call(VEC_ADDR[SRC_TMR0]);
		ret();
		hold <= 1'b1;
		pulse(3'h1);
		no_call(40);
		hold <= 1'b0;
		wait_call(VEC_ADDR[SRC_TMR0]);
		ret();
	endtask
	task automatic t_serial();
		wr(OFS_ENABLE, 32'h90);
		ser_err <= 1'b1;
		pulse(3'h4);
		ser_err <= 1'b0;
		no_call(40);
		pulse(3'h4);
		wait_call(VEC_ADDR[SRC_SER]);
		ret();
	endtask
	task automatic t_ext();
		wr(OFS_CTRL, 32'h01);
		wr(OFS_ENABLE, 32'h81);
		pin0_n <= 1'b0;
		wait_call(VEC_ADDR[SRC_EXT0]);
		pin0_n <= 1'b1;
		rd(OFS_STATUS);
		chk("edge_clr", 32'(st[0]), 32'h0);
		ret();
		wr(OFS_CTRL, 32'h00);
		pin0_n <= 1'b0;
		wait_call(VEC_ADDR[SRC_EXT0]);
		rd(OFS_STATUS);
		chk("level_kept", 32'(st[0]), 32'h1);
		pin0_n <= 1'b1;
		repeat (30) @(posedge clk);
		rd(OFS_STATUS);
		chk("level_follow", 32'(st[0]), 32'h0);
		ret();
		no_call(40);
	endtask
	task automatic t_preempt();
		slow <= 1'b1;
		wr(OFS_PRIO, 32'h04);
		wr(OFS_CTRL, 32'h04);
		wr(OFS_ENABLE, 32'h86);
		pulse(3'h1);
		wait_call(VEC_ADDR[SRC_TMR0]);
		pin1_n <= 1'b0;
		wait_call(VEC_ADDR[SRC_EXT1]);
		pin1_n <= 1'b1;
		rd(OFS_STATUS);
		chk("in_service", 32'(st[7:6]), 32'h3);
		pulse(3'h1);
		no_call(40);
		ret();
		no_call(40);
		ret();
		wait_call(VEC_ADDR[SRC_TMR0]);
		ret();
		slow <= 1'b0;
	endtask
	task automatic t_irq();
		logic a;
		wr(OFS_IRQ_MASK, 32'h03);
		repeat (2) @(posedge clk);
		a = irq;
		wr(OFS_IRQ_MASK, 32'h00);
		repeat (2) @(posedge clk);
		chk("irq_on", 32'(a), 32'h1);
		chk("irq_mask", 32'(irq), 32'h0);
		wr(OFS_IRQ_STAT, 32'h03);
		rd(OFS_IRQ_STAT);
		chk("irq_w1c", st & 32'h03, 32'h0);
		chk("irq_clr0", 32'(irq), 32'h0);
		wr(OFS_IRQ_MASK, 32'h03);
		repeat (2) @(posedge clk);
		chk("irq_clr1", 32'(irq), 32'h0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{rst, hsel, hwrite, tmr0, tmr1, ser_done, ser_err, hold, slow, ret_go} <= 10'h200;
		{pin0_n, pin1_n} <= 2'h3;
		haddr <= 8'h00;
		htrans <= 2'h0;
		hsize <= 3'h2;
		hwdata <= 32'h0;
		bad_count = 0;
		n_compared = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_tick();
		t_order();
		t_gate();
		t_serial();
		t_ext();
		t_preempt();
		t_irq();
		results();
	end
	// Whole run needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		results();
	end
endmodule // irq_ctrl_tb
